// ===== pkg/rst_seq_pkg.sv
// constants, encodings and register map of the reset and timeout sequencer
package rst_seq_pkg;

  // clock and time figures
  localparam int CLK_PERIOD_NS = 50;
  localparam int RC_OSC_HZ = 31250;
  localparam int POWER_UP_DELAY_COUNTER_MS = 72;
  localparam int POWER_UP_DELAY_COUNTER_TICKS = POWER_UP_DELAY_COUNTER_MS * RC_OSC_HZ / 1000;
  localparam int OST_TICKS = 1024;
  localparam int CPU_START_NS = 5000;
  localparam int CPU_START_CYC =
    (CPU_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOR_MIN_NS = 100000;
  localparam int BOR_MIN_CYC = (BOR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASTER_CLEAR_PIN_FILT_NS = 2000;
  localparam int MASTER_CLEAR_PIN_FILT_CYC =
    (MASTER_CLEAR_PIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register offsets (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CAUSE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h8;

  // power_reset_cause fields
  localparam int CAUSE_BOR_BIT = 0;
  localparam int CAUSE_POR_BIT = 1;
  // status fields
  localparam int STAT_TO_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_KIND_LSB = 2;
  localparam int STAT_RST_BIT = 5;
  localparam int STAT_HOLD_BIT = 6;
  // config fields and value after reset
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_POWER_UP_DELAY_COUNTER_BIT = 3;
  localparam int CFG_BROWN_OUT_ENABLE_CFG_BIT = 4;
  localparam int CFG_MASTER_CLEAR_PIN_SELECT_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h3f;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // oscillator modes
  typedef enum logic [2:0] {
    OSC_LOW_POWER = 3'h0,
    OSC_CRYSTAL = 3'h1,
    OSC_HIGH_SPEED = 3'h2,
    OSC_EXT_CLOCK = 3'h3,
    OSC_INT_RC_IO = 3'h4,
    OSC_INT_RC = 3'h5,
    OSC_EXT_RC_IO = 3'h6,
    OSC_EXT_RC = 3'h7
  } osc_mode_t;

  // sequencer states
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_BOR_HOLD = 5'h02,
    ST_POWER_UP_DELAY_COUNTER = 5'h04,
    ST_OST = 5'h08,
    ST_CPU = 5'h10
  } seq_state_t;

  // decoded cause of the last reset
  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'h0,
    CAUSE_BROWN_OUT = 3'h1,
    CAUSE_WDT_RESET = 3'h2,
    CAUSE_WDT_WAKE = 3'h3,
    CAUSE_MASTER_CLEAR_PIN_SLEEP_INT = 3'h4,
    CAUSE_MASTER_CLEAR_PIN_RUN = 3'h5,
    CAUSE_ILLEGAL = 3'h6
  } cause_t;

endpackage : rst_seq_pkg

// ===== pkg/pin_if.sv
// one filtered pin: raw level in, clean level and rising pulse out
`timescale 1ns/100ps
interface pin_if;
  logic raw;
  logic level;
  logic rise;
  modport filt (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface : pin_if

// ===== hdl/pin_filter.sv
// three-stage synchroniser with a stability filter on one pin
`timescale 1ns/100ps
module pin_filter #(
  parameter int STABLE_CYC = 1,
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // filtered pin
  pin_if.filt pin
);
  localparam int CW = $clog2(STABLE_CYC + 1);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic [CW-1:0] cnt_reg;
  logic level_reg;
  logic rise_reg;
  logic agree;

  if (STABLE_CYC < 1) begin : g_chk
    $error("pin_filter needs STABLE_CYC of at least 1");
  end

  // synchroniser chain, first stage read only by the second
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end
    else
    begin
      s1_reg <= pin.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign agree = (s2_reg == s3_reg);

  // new level accepted after a stable run, short pulses dropped
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= '0;
      level_reg <= INIT;
      rise_reg <= 1'b0;
    end
    else
    begin
      rise_reg <= 1'b0;
      if (agree && (s3_reg != level_reg))
      begin
        if (cnt_reg == CW'(STABLE_CYC - 1))
        begin
          cnt_reg <= '0;
          level_reg <= s3_reg;
          rise_reg <= s3_reg;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
      else
        cnt_reg <= '0;
    end
  end

  assign pin.level = level_reg;
  assign pin.rise = rise_reg;

endmodule : pin_filter

// ===== hdl/reset_timeout_sequencer.sv
// reset and start-up timeout sequencer with axi4-lite registers
// Operation
// - master-clear input is glitch filtered; short pulses never reset.
// - watchdog reset acts inside only; master-clear pin is never driven.
// - shared pin is master-clear by default; config bit frees it.
// - power-up delay counts internal rc oscillator edges, nominal 72 ms.
// - core stays in reset while the power-up delay runs.
// - power-up delay config bit: 0 enables, 1 bypasses.
// - oscillator settle counts 1024 edges, after power-up delay ends.
// - settle delay only in crystal modes, on power-on, brown-out, wake.
// - one config bit enables or disables brown-out reset.
// - enabled low supply longer than about 100 us resets device.
// - brown-out holds reset while low, then adds power-up delay.
// - supply dip during post brown-out delay restarts the whole sequence.
// - brown-out enable and power-up delay enable act independently.
// - power-up runs delay, then settle count, release after the last.
// - master-clear held past all delays starts execution at its release.
// - core start-up delay 5-10 us always on power-on, brown-out, wake.
// - cause register bit 0 brown-out flag, bit 1 power-on flag.
// - brown-out reset clears brown-out flag; software sets it again.
// - power-on clears power-on flag, others leave it; software sets it.
// - power-on sets timeout and power-down flags.
// - flags decode to brown-out, watchdog reset, wake, master-clear.
// - resets reset the core; watchdog wake only resumes it.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module reset_timeout_sequencer
  import rst_seq_pkg::*;
#(
  parameter int POWER_UP_DELAY_COUNTER_TICKS_P = POWER_UP_DELAY_COUNTER_TICKS,
  parameter int OST_TICKS_P = OST_TICKS,
  parameter int CPU_START_CYC_P = CPU_START_CYC,
  parameter int BOR_MIN_CYC_P = BOR_MIN_CYC,
  parameter int MASTER_CLEAR_PIN_FILT_CYC_P = MASTER_CLEAR_PIN_FILT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins and analog detectors
  input wire logic master_clear_pin_n,
  input wire logic osc_input_pin,
  input wire logic internal_rc_osc,
  input wire logic power_on_detect,
  input wire logic brown_out_detect,
  // core side
  input wire logic core_sleep,
  input wire logic watchdog_timer_event,
  input wire logic interrupt_wake,
  output logic core_reset,
  output logic core_hold
);
  localparam int PW = $clog2(POWER_UP_DELAY_COUNTER_TICKS_P + 1);
  localparam int OW = $clog2(OST_TICKS_P + 1);
  localparam int CCW = $clog2(CPU_START_CYC_P + 1);

  if (POWER_UP_DELAY_COUNTER_TICKS_P < 1 || OST_TICKS_P < 1 || CPU_START_CYC_P < 1)
  begin : g_chk
    $error("sequencer counts must be at least 1");
  end

  pin_if master_clear_pin_p ();
  pin_if osc_p ();
  pin_if rc_p ();
  pin_if por_p ();
  pin_if bor_p ();

  assign master_clear_pin_p.raw = master_clear_pin_n;
  assign osc_p.raw = osc_input_pin;
  assign rc_p.raw = internal_rc_osc;
  assign por_p.raw = power_on_detect;
  assign bor_p.raw = brown_out_detect;

  pin_filter #(.STABLE_CYC(MASTER_CLEAR_PIN_FILT_CYC_P), .INIT(1'b1)) u_master_clear_pin (
    .sys_clk(sys_clk), .rstn(rstn), .pin(master_clear_pin_p));
  pin_filter #(.STABLE_CYC(1), .INIT(1'b0)) u_osc (
    .sys_clk(sys_clk), .rstn(rstn), .pin(osc_p));
  pin_filter #(.STABLE_CYC(1), .INIT(1'b0)) u_rc (
    .sys_clk(sys_clk), .rstn(rstn), .pin(rc_p));
  pin_filter #(.STABLE_CYC(1), .INIT(1'b0)) u_por (
    .sys_clk(sys_clk), .rstn(rstn), .pin(por_p));
  // low supply must last the minimum time
  pin_filter #(.STABLE_CYC(BOR_MIN_CYC_P), .INIT(1'b0)) u_bor (
    .sys_clk(sys_clk), .rstn(rstn), .pin(bor_p));

  seq_state_t state_reg, state_next;
  logic wake_reg, wake_next;
  logic boot_reg;
  logic sleep_d_reg;
  logic [7:0] cfg_reg;
  logic [PW-1:0] power_up_delay_counter_cnt_reg;
  logic [OW-1:0] ost_cnt_reg;
  logic [CCW-1:0] cpu_cnt_reg;
  logic por_flag_reg;
  logic bor_flag_reg;
  logic timeout_flag_reg;
  logic power_down_flag_reg;
  logic core_reset_reg;
  logic core_hold_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_got_reg, w_got_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic por_evt, bor_active, master_clear_pin_active, crystal, power_up_delay_counter_on;
  logic wdt_reset_evt, wake_evt, sleep_entry, start_seq;
  logic power_up_delay_counter_done, ost_done, wr_fire;
  seq_state_t first_stage, after_power_up_delay_counter;
  cause_t cause;

  // event and configuration decode
  assign por_evt = boot_reg | por_p.rise;
  // brown-out gated by its own enable
  assign bor_active = bor_p.level & cfg_reg[CFG_BROWN_OUT_ENABLE_CFG_BIT];
  // freed pin keeps internal master-clear inactive
  assign master_clear_pin_active = cfg_reg[CFG_MASTER_CLEAR_PIN_SELECT_BIT] & ~master_clear_pin_p.level;
  // settle delay only for the crystal modes
  assign crystal = (cfg_reg[CFG_OSC_LSB +: 3] == OSC_LOW_POWER) ||
                   (cfg_reg[CFG_OSC_LSB +: 3] == OSC_CRYSTAL) ||
                   (cfg_reg[CFG_OSC_LSB +: 3] == OSC_HIGH_SPEED);
  // delay bit low enables, high bypasses
  assign power_up_delay_counter_on = ~cfg_reg[CFG_POWER_UP_DELAY_COUNTER_BIT];
  assign wdt_reset_evt = watchdog_timer_event & ~core_sleep & ~por_evt;
  assign wake_evt = (watchdog_timer_event | interrupt_wake) & core_sleep &
                    (state_reg == ST_RUN) & ~por_evt & ~bor_active;
  assign sleep_entry = core_sleep & ~sleep_d_reg;
  // settle count follows the power-up delay
  assign after_power_up_delay_counter = crystal ? ST_OST : ST_CPU;
  assign first_stage = power_up_delay_counter_on ? ST_POWER_UP_DELAY_COUNTER : after_power_up_delay_counter;
  // power-up delay counts rc oscillator edges
  assign power_up_delay_counter_done = (state_reg == ST_POWER_UP_DELAY_COUNTER) & rc_p.rise &
                     (power_up_delay_counter_cnt_reg == PW'(POWER_UP_DELAY_COUNTER_TICKS_P - 1));
  assign ost_done = (state_reg == ST_OST) & osc_p.rise &
                    (ost_cnt_reg == OW'(OST_TICKS_P - 1));

  always_comb
  begin
    state_next = state_reg;
    wake_next = wake_reg;
    start_seq = 1'b0;
    if (por_evt)
    begin
      state_next = first_stage;
      wake_next = 1'b0;
      start_seq = 1'b1;
    end
    // any dip returns to hold and restarts
    else if (bor_active)
    begin
      state_next = ST_BOR_HOLD;
      wake_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_BOR_HOLD:
        begin
          state_next = first_stage;
          start_seq = 1'b1;
        end
        ST_POWER_UP_DELAY_COUNTER:
          if (power_up_delay_counter_done)
            state_next = after_power_up_delay_counter;
        ST_OST:
          if (ost_done)
            state_next = ST_CPU;
        ST_CPU:
          if (cpu_cnt_reg == '0)
          begin
            state_next = ST_RUN;
            wake_next = 1'b0;
          end
        ST_RUN:
          if (wake_evt)
          begin
            state_next = after_power_up_delay_counter;
            wake_next = 1'b1;
            start_seq = 1'b1;
          end
        default:
          state_next = ST_BOR_HOLD;
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_RUN;
      wake_reg <= 1'b0;
      boot_reg <= 1'b1;
      sleep_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wake_reg <= wake_next;
      boot_reg <= 1'b0;
      sleep_d_reg <= core_sleep;
    end
  end

  // delay counters, cleared outside their own state
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      power_up_delay_counter_cnt_reg <= '0;
      ost_cnt_reg <= '0;
    end
    else
    begin
      if (state_reg != ST_POWER_UP_DELAY_COUNTER || power_up_delay_counter_done)
        power_up_delay_counter_cnt_reg <= '0;
      else if (rc_p.rise)
        power_up_delay_counter_cnt_reg <= power_up_delay_counter_cnt_reg + 1'b1;
      if (state_reg != ST_OST || ost_done)
        ost_cnt_reg <= '0;
      else if (osc_p.rise)
        ost_cnt_reg <= ost_cnt_reg + 1'b1;
    end
  end

  // core start-up delay, parallel to other timers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cpu_cnt_reg <= '0;
    else if (start_seq)
      cpu_cnt_reg <= CCW'(CPU_START_CYC_P);
    else if (cpu_cnt_reg != '0)
      cpu_cnt_reg <= cpu_cnt_reg - 1'b1;
  end

  // merged core reset; held during delays
  // wake holds the core without resetting it
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      core_reset_reg <= 1'b1;
      core_hold_reg <= 1'b0;
    end
    else
    begin
      core_reset_reg <= ((state_next != ST_RUN) & ~wake_next) |
                        master_clear_pin_active | wdt_reset_evt;
      core_hold_reg <= (state_next != ST_RUN) & wake_next;
    end
  end

  // timeout and power-down flags per reset kind
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b1;
    end
    else if (por_evt || bor_active)
    begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b1;
    end
    else if (wdt_reset_evt)
    begin
      timeout_flag_reg <= 1'b0;
      power_down_flag_reg <= 1'b1;
    end
    else if (wake_evt && watchdog_timer_event)
    begin
      timeout_flag_reg <= 1'b0;
      power_down_flag_reg <= 1'b0;
    end
    else if (sleep_entry)
    begin
      timeout_flag_reg <= 1'b1;
      power_down_flag_reg <= 1'b0;
    end
  end

  // cause flags; hardware clear wins over software write
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      por_flag_reg <= 1'b0;
      bor_flag_reg <= 1'b0;
    end
    else
    begin
      if (por_evt)
        por_flag_reg <= 1'b0;
      else if (wr_fire && waddr_reg == OFS_CAUSE && wstrb_reg[0])
        por_flag_reg <= wdata_reg[CAUSE_POR_BIT];
      if (bor_active)
        bor_flag_reg <= 1'b0;
      else if (wr_fire && waddr_reg == OFS_CAUSE && wstrb_reg[0])
        bor_flag_reg <= wdata_reg[CAUSE_BOR_BIT];
    end
  end

  // cause decode from the four flags
  always_comb
  begin
    if (!por_flag_reg)
      cause = (timeout_flag_reg && power_down_flag_reg) ? CAUSE_POWER_ON
                                                        : CAUSE_ILLEGAL;
    else if (!bor_flag_reg && timeout_flag_reg && power_down_flag_reg)
      cause = CAUSE_BROWN_OUT;
    else if (!timeout_flag_reg)
      cause = power_down_flag_reg ? CAUSE_WDT_RESET : CAUSE_WDT_WAKE;
    else if (!power_down_flag_reg)
      cause = CAUSE_MASTER_CLEAR_PIN_SLEEP_INT;
    else
      cause = CAUSE_MASTER_CLEAR_PIN_RUN;
  end

  // write channel: address and data taken in either order
  assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      if (awvalid && awready_reg)
      begin
        waddr_reg <= awaddr;
        aw_got_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (wvalid && wready_reg)
      begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
        w_got_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (waddr_reg == OFS_CAUSE || waddr_reg == OFS_STATUS ||
                      waddr_reg == OFS_CONFIG) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && bready)
      begin
        bvalid_reg <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // configuration register, low byte only
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cfg_reg <= CFG_RESET;
    else if (wr_fire && waddr_reg == OFS_CONFIG && wstrb_reg[0])
      cfg_reg <= {2'h0, wdata_reg[5:0]};
  end

  // read channel, answer one cycle after the address
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
      case (araddr)
        OFS_CAUSE:
          rdata_reg <= {30'h0, por_flag_reg, bor_flag_reg};
        OFS_STATUS:
          rdata_reg <= {25'h0, core_hold_reg, core_reset_reg, cause,
                        power_down_flag_reg, timeout_flag_reg};
        OFS_CONFIG:
          rdata_reg <= {24'h0, cfg_reg};
        default:
          rresp_reg <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // outputs straight from flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign core_reset = core_reset_reg;
  assign core_hold = core_hold_reg;

  // checks on the sequencer
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_por_flag_clear: assert property (por_evt |=> !por_flag_reg)
    else $error("power-on flag not cleared by power-on");
  a_bor_flag_clear: assert property (bor_active |=> !bor_flag_reg)
    else $error("brown-out flag not cleared by brown-out");
  a_por_sets_flags: assert property (
    por_evt |=> timeout_flag_reg && power_down_flag_reg)
    else $error("power-on did not set timeout and power-down");
  a_delay_holds_core: assert property (
    (state_reg == ST_POWER_UP_DELAY_COUNTER) && !por_evt && !bor_active |=> core_reset_reg)
    else $error("core left out of reset during power-up delay");
  a_master_clear_pin_freed_pin: assert property (
    !cfg_reg[CFG_MASTER_CLEAR_PIN_SELECT_BIT] && (state_next == ST_RUN) && !wdt_reset_evt
    |=> !core_reset_reg)
    else $error("master-clear active while pin is general io");
  a_power_up_delay_counter_bypass: assert property (
    por_evt && cfg_reg[CFG_POWER_UP_DELAY_COUNTER_BIT] |=> state_reg != ST_POWER_UP_DELAY_COUNTER)
    else $error("power-up delay ran while bypassed");
  a_ost_crystal_only: assert property (
    $rose(state_reg == ST_OST) |-> crystal)
    else $error("settle count outside crystal modes");
  a_bor_restart: assert property (
    (state_reg == ST_POWER_UP_DELAY_COUNTER) && bor_active && !por_evt
    |=> (state_reg == ST_BOR_HOLD) ##1 (power_up_delay_counter_cnt_reg == '0))
    else $error("brown-out during delay did not restart");
  a_wdt_flags: assert property (
    wdt_reset_evt && !bor_active
    |=> !timeout_flag_reg && power_down_flag_reg && core_reset_reg)
    else $error("watchdog reset flags or reset wrong");

endmodule : reset_timeout_sequencer

// ===== test/core_model.sv
// core and software stand-in that raises sleep and wake events
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // from the sequencer
  input wire logic core_reset,
  input wire logic core_hold,
  // commands from the bench
  input wire logic sleep_cmd,
  input wire logic wdt_cmd,
  input wire logic int_cmd,
  // to the sequencer
  output logic core_sleep,
  output logic watchdog_timer_event,
  output logic interrupt_wake
);
  // resume after hold
  // sleep level, left on reset or once the wake hold starts
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      core_sleep <= 1'h0;
    else if (core_reset || core_hold)
      core_sleep <= 1'h0;
    else if (sleep_cmd)
      core_sleep <= 1'h1;
  end
  // one-cycle event pulses
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      watchdog_timer_event <= 1'h0;
      interrupt_wake <= 1'h0;
    end
    else
    begin
      watchdog_timer_event <= wdt_cmd;
      interrupt_wake <= int_cmd;
    end
  end
endmodule : core_model

// ===== test/testbench.sv
// self-checking bench of the reset and timeout sequencer
`timescale 1ns/100ps
module testbench;
  import rst_seq_pkg::*;
  typedef struct {logic w; logic [3:0] a; logic [7:0] d, e;
    logic [1:0] r;} row_t;
  logic sys_clk = 1'h0, rstn = 1'h0, seen, hs;
  logic [3:0] awaddr = '0, araddr = '0, div = '0, wstrb = 4'hf;
  logic [2:0] awprot = '0, arprot = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic master_clear_pin_n = 1'h1, power_on_detect = 1'h0;
  logic brown_out_detect = 1'h0;
  logic sleep_cmd = 1'h0, wdt_cmd = 1'h0, int_cmd = 1'h0;
  logic core_sleep, watchdog_timer_event, interrupt_wake;
  logic core_reset, core_hold;
  int error_cnt = 0, checks_done = 0, tick = 0, n;
  row_t rows [9] = '{
    '{1'h0, 4'h8, 8'h00, 8'h3f, 2'h0}, '{1'h0, 4'h0, 8'h00, 8'h00, 2'h0},
    '{1'h0, 4'h4, 8'h00, 8'h03, 2'h0}, '{1'h1, 4'h0, 8'h03, 8'h00, 2'h0},
    '{1'h0, 4'h0, 8'h00, 8'h03, 2'h0}, '{1'h1, 4'h4, 8'hff, 8'h00, 2'h0},
    '{1'h0, 4'h4, 8'h00, 8'h17, 2'h0}, '{1'h0, 4'hc, 8'h00, 8'h00, 2'h2},
    '{1'h1, 4'hc, 8'h00, 8'h00, 2'h2}};

  reset_timeout_sequencer #(.POWER_UP_DELAY_COUNTER_TICKS_P(4), .OST_TICKS_P(8),
    .CPU_START_CYC_P(3), .BOR_MIN_CYC_P(5), .MASTER_CLEAR_PIN_FILT_CYC_P(3)) DUT (
    .sys_clk, .rstn, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .master_clear_pin_n, .osc_input_pin(div[2]),
    .internal_rc_osc(div[3]), .power_on_detect, .brown_out_detect,
    .core_sleep, .watchdog_timer_event, .interrupt_wake, .core_reset,
    .core_hold);
  core_model partner (.sys_clk, .rstn, .core_reset, .core_hold,
    .sleep_cmd, .wdt_cmd, .int_cmd, .core_sleep, .watchdog_timer_event,
    .interrupt_wake);

  // clock, oscillators and hang guard
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    div <= div + 4'h1;
    tick <= tick + 1;
    if (tick == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  // watch the core outputs for k cycles
  task watch(input int k);
    seen = 1'h0;
    hs = 1'h0;
    repeat (k)
    begin
      @(negedge sys_clk);
      seen |= core_reset;
      hs |= core_hold;
      @(posedge sys_clk);
    end
  endtask : watch

  // cycles until the core leaves reset
  task rel(output int c);
    c = 0;
    @(negedge sys_clk);
    while (core_reset !== 1'h0)
    begin
      @(negedge sys_clk);
      c++;
    end
    @(posedge sys_clk);
  endtask : rel

  task axw(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    while (!tb)
    begin
      @(negedge sys_clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    cyc(1);
  endtask : axw

  task axr(input logic [3:0] a);
    logic t, v;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    v = 1'h0;
    while (!v)
    begin
      @(negedge sys_clk);
      t = arready;
      v = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge sys_clk);
      if (t) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    cyc(1);
  endtask : axr

  task dip;
    brown_out_detect <= 1'h1;
    watch(20);
    chk("bor hold", seen, 1);
    brown_out_detect <= 1'h0;
  endtask : dip

  // sleep, then wake by watchdog or interrupt
  task nap(input logic w, input logic [4:0] e);
    sleep_cmd <= 1'h1;
    cyc(1);
    sleep_cmd <= 1'h0;
    cyc(3);
    wdt_cmd <= w;
    int_cmd <= !w;
    cyc(1);
    wdt_cmd <= 1'h0;
    int_cmd <= 1'h0;
    watch(20);
    chk("wake reset", seen, 0);
    chk("wake hold", hs, 1);
    axr(OFS_STATUS);
    chk("wake flags", rd[4:0], e);
  endtask : nap

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    cyc(3);
    chk("reset out", {core_reset, core_hold}, 2'h2);
    rstn <= 1'h1;
    rel(n);
    foreach (rows[i])
    begin
      if (rows[i].w) axw(rows[i].a, rows[i].d);
      else axr(rows[i].a);
      if (!rows[i].w) chk("row data", rd[7:0], rows[i].e);
      chk("row resp", rsp, rows[i].r);
    end
    $display("test registers done");
    master_clear_pin_n <= 1'h0;
    cyc(1);
    master_clear_pin_n <= 1'h1;
    watch(12);
    chk("master_clear_pin glitch", seen, 0);
    master_clear_pin_n <= 1'h0;
    watch(12);
    chk("master_clear_pin hold", seen, 1);
    axr(OFS_STATUS);
    chk("master_clear_pin status", rd[5:0], 6'h37);
    master_clear_pin_n <= 1'h1;
    rel(n);
    chk("master_clear_pin exit", n < 12, 1);
    axw(OFS_CONFIG, 8'h1f);
    master_clear_pin_n <= 1'h0;
    watch(12);
    chk("pin as io", seen, 0);
    master_clear_pin_n <= 1'h1;
    watch(12);
    axw(OFS_CONFIG, 8'h3f);
    $display("test master clear done");
    wdt_cmd <= 1'h1;
    cyc(1);
    wdt_cmd <= 1'h0;
    watch(8);
    chk("wdt reset", seen, 1);
    axr(OFS_STATUS);
    chk("wdt status", rd[4:0], 5'h0a);
    axr(OFS_CAUSE);
    chk("wdt cause", rd[1:0], 2'h3);
    nap(1'h0, 5'h11);
    nap(1'h1, 5'h0c);
    $display("test watchdog and sleep done");
    axw(OFS_CONFIG, 8'h31);
    brown_out_detect <= 1'h1;
    cyc(2);
    brown_out_detect <= 1'h0;
    watch(12);
    chk("short dip", seen, 0);
    dip();
    cyc(20);
    dip();
    rel(n);
    chk("bor restart", n > 105, 1);
    axr(OFS_CAUSE);
    chk("bor cause", rd[1:0], 2'h2);
    axr(OFS_STATUS);
    chk("bor status", rd[4:0], 5'h07);
    axw(OFS_CONFIG, 8'h2f);
    brown_out_detect <= 1'h1;
    watch(20);
    chk("bor off", seen, 0);
    brown_out_detect <= 1'h0;
    watch(12);
    axw(OFS_CONFIG, 8'h3f);
    dip();
    rel(n);
    chk("no delay", n < 30, 1);
    $display("test brown-out done");
    power_on_detect <= 1'h1;
    watch(8);
    chk("por event", seen, 1);
    power_on_detect <= 1'h0;
    rel(n);
    axr(OFS_CAUSE);
    chk("por cause", rd[1:0], 2'h0);
    $display("test power-on done");
    tally_and_finish();
  end
endmodule : testbench
